// ### rtl/fsp_pkg.sv
// Package with constants and types for the flash self-programming sequencer
package fsp_pkg;
    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0]  FSP_CTRL_OFS      = 4'h0;  // self_program_control_reg
    localparam logic [3:0]  FSP_ADDR_OFS      = 4'h4;  // Target word address pointer
    localparam logic [3:0]  FSP_LOCK_OFS      = 4'h8;  // Lock bits, both sets
    localparam logic [3:0]  FSP_STAT_OFS      = 4'hC;  // Status
    // Control register fields
    localparam int          FSP_CTRL_GO_BIT   = 0;     // Store instruction strobe
    localparam int          FSP_CTRL_ERASE_BIT= 1;     // 1 erase, 0 write
    localparam int          FSP_CTRL_LOCK_BIT = 2;     // Not decoded; lock bits are set through the lock register
    localparam int          FSP_CTRL_CLR_BIT  = 3;     // Write 1 clears busy flag
    localparam int          FSP_CTRL_BUSY_BIT = 6;     // concurrent_region_busy_flag
    // Flash geometry in word addresses
    localparam int          FSP_AW            = 12;
    localparam int          FSP_PAGE_BITS     = 5;
    localparam logic [11:0] FSP_HALT_BASE     = 12'hC00; // Fixed halting region start
    // Loader start per loader_size_fuses code, all at or above the halting base
    localparam logic [11:0] FSP_LDR_BASE_0    = 12'hC00;
    localparam logic [11:0] FSP_LDR_BASE_1    = 12'hE00;
    localparam logic [11:0] FSP_LDR_BASE_2    = 12'hF00;
    localparam logic [11:0] FSP_LDR_BASE_3    = 12'hF80;
    // Lock bits reset to unprogrammed (1)
    localparam logic [3:0]  FSP_LOCK_RESET    = 4'hF;
    // Operation time
    localparam int          FSP_CLK_MHZ       = 10;
    localparam int          FSP_PROG_US       = 4000;
    localparam int          FSP_PROG_CYCLES   = FSP_PROG_US * FSP_CLK_MHZ;
    localparam logic [1:0]  FSP_RESP_OKAY     = 2'b00;
    localparam logic [1:0]  FSP_RESP_SLVERR   = 2'b10;
    typedef enum logic [2:0] {
        FSP_IDLE = 3'b001,
        FSP_RUN  = 3'b010,
        FSP_DONE = 3'b100
    } fsp_state_type;
endpackage : fsp_pkg

// ### rtl/fsp_sequencer.sv
// Flash self-programming sequencer with loader region and concurrent-read control
//
// Behaviour
// RQ1: Store instruction starts erase/write only when fetched from the loader region.
// RQ2: From the loader region any page of the flash may be targeted.
// RQ3: Loader size fuses set the application/loader boundary.
// RQ4: Application lock bits protect the application region independently.
// RQ5: Loader lock bits protect the loader region separately.
// RQ6: Fixed boundary splits flash into concurrent-read and halting regions.
// RQ7: Programming concurrent-read page keeps CPU running, halting region readable.
// RQ8: Programming halting page stalls CPU whole operation; nothing readable.
// RQ9: Software must not touch concurrent-read code while it is programmed.
// RQ10: Software should disable or relocate interrupts while programming that region.
// RQ11: Busy flag reads one while concurrent-read region is blocked.
// RQ12: Busy flag stays set after completion until software clears it.
// RQ13: Loader region always lies wholly inside the halting region.
// RQ14: Stall choice depends on target page region, not the fetch region.
// RQ15: Lock bits set by software or programmer; cleared only by chip erase. Here reset also restores them.
// RQ16: Target address is latched at start; pointer may then change.
// RQ17: Stall output asserted from start to completion for halting-region targets.
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module fsp_sequencer
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES = FSP_PROG_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    // AXI4-Lite slave
    input  wire logic [3:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [3:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // CPU side
    input  wire logic [FSP_AW-1:0] cpu_fetch_addr,      // Address the CPU executes from
    input  wire logic [1:0]        loader_size_fuses,   // Static fuse setting
    input  wire logic              chip_erase,          // External programmer chip erase
    input  wire logic              prog_lock_we,        // External programmer lock write
    input  wire logic [3:0]        prog_lock_data,
    output logic                   cpu_stall,
    output logic                   concurrent_read_block,
    // Flash array side
    output logic                   flash_op_start,
    output logic                   flash_op_erase,
    output logic [FSP_AW-1:0]      flash_op_addr,
    input  wire logic              flash_op_done
);

    // Sequencer, pointer and lock state
    fsp_state_type               state;
    logic [FSP_AW-1:0]           addr_ptr;
    logic [3:0]                  lock_bits;      // [3:2] loader set, [1:0] application set
    logic                        busy_flag;
    logic                        denied;
    logic [15:0]                 op_count;
    logic                        timed_out;

    // Write channel holding registers
    logic                        aw_held;
    logic                        w_held;
    logic [3:0]                  aw_addr;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;

    // Synchroniser stages
    logic [1:0]                  fuse_q1;
    logic [1:0]                  fuse_q2;
    logic                        erase_q1;
    logic                        erase_q2;
    logic                        done_q1;
    logic                        done_q2;

    // Decode and request terms
    logic [FSP_AW-1:0]           ldr_base;
    logic                        from_loader;
    logic                        target_in_loader;
    logic                        target_in_halt;
    logic                        write_locked;
    logic                        wr_fire;
    logic                        go_req;
    logic                        lock_req;
    logic                        clr_req;
    logic                        start_ok;
    logic [31:0]                 ctrl_read;

    // Lock masks and next-cycle bus views
    logic [3:0]                  sw_lock_mask;
    logic [3:0]                  pin_lock_mask;
    logic                        next_aw_held;
    logic                        next_w_held;
    logic                        next_bvalid;
    logic                        next_rvalid;

    // Fuse, chip-erase and done inputs pass two flip-flops before use
    // Fuses are static; the stages only shield against metastability
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fuse_q1  <= 2'b00;
            fuse_q2  <= 2'b00;
            erase_q1 <= 1'b0;
            erase_q2 <= 1'b0;
            done_q1  <= 1'b0;
            done_q2  <= 1'b0;
        end else begin
            fuse_q1  <= loader_size_fuses;
            fuse_q2  <= fuse_q1;
            erase_q1 <= chip_erase;
            erase_q2 <= erase_q1;
            done_q1  <= flash_op_done;
            done_q2  <= done_q1;
        end
    end

    // Region decode; every loader base sits at or above the halting base
    // A new fuse code takes effect two cycles after it settles
    always_comb begin
        case (fuse_q2)                                               // [RQ3]
            2'd0:    ldr_base = FSP_LDR_BASE_0;
            2'd1:    ldr_base = FSP_LDR_BASE_1;
            2'd2:    ldr_base = FSP_LDR_BASE_2;
            default: ldr_base = FSP_LDR_BASE_3;
        endcase
    end
    assign from_loader      = cpu_fetch_addr >= ldr_base;            // [RQ1] [RQ13]
    assign target_in_loader = addr_ptr >= ldr_base;                  // [RQ2]
    assign target_in_halt   = addr_ptr >= FSP_HALT_BASE;             // [RQ6] [RQ14]
    // Lock pair 2'b11 is free; either zero bit forbids writes here
    // Read restrictions of the lock pairs are not modelled
    assign write_locked     = target_in_loader ? (lock_bits[3:2] != 2'b11)  // [RQ5]
                                               : (lock_bits[1:0] != 2'b11); // [RQ4]

    // Write channel capture; address and data may come in either order
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= 4'h0;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held <= 1'b0;
            end
        end
    end
    // Next-cycle channel view, so each ready can come from a flip-flop
    assign next_aw_held  = (s_axi_awvalid && s_axi_awready) || (aw_held && !wr_fire);
    assign next_w_held   = (s_axi_wvalid && s_axi_wready) || (w_held && !wr_fire);
    assign next_bvalid   = wr_fire || (s_axi_bvalid && !s_axi_bready);

    // Ready is low while a beat is held or the response waits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready  <= !next_w_held && !next_bvalid;
        end
    end

    // Write response; unaligned offsets answer with a slave error
    // Aligned holes answer OKAY and are ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= FSP_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[1:0] == 2'b00) ? FSP_RESP_OKAY : FSP_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Requests decoded from the captured address and data
    assign go_req   = wr_fire && aw_addr == FSP_CTRL_OFS && w_strb[0] && w_data[FSP_CTRL_GO_BIT];
    assign lock_req = wr_fire && aw_addr == FSP_LOCK_OFS && w_strb[0] && from_loader;
    assign clr_req  = wr_fire && aw_addr == FSP_CTRL_OFS && w_strb[0] && w_data[FSP_CTRL_CLR_BIT];
    assign start_ok = go_req && from_loader && !write_locked && state == FSP_IDLE;   // [RQ1]
    // All-ones mask when a source is silent
    assign sw_lock_mask  = lock_req ? w_data[3:0] : 4'hF;
    assign pin_lock_mask = prog_lock_we ? prog_lock_data : 4'hF;

    // Address pointer, freely writable even while an operation runs
    // The running operation already holds its own latched page
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_ptr <= '0;
        end else if (wr_fire && aw_addr == FSP_ADDR_OFS && w_strb[1:0] == 2'b11) begin
            addr_ptr <= w_data[FSP_AW-1:0];
        end
    end

    // Lock bits only move from 1 to 0; only chip erase or reset restores them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_bits <= FSP_LOCK_RESET;
        end else if (erase_q2) begin
            lock_bits <= FSP_LOCK_RESET;                             // [RQ15]
        end else begin
            // Software and programmer may write in one cycle; both must stick
            lock_bits <= lock_bits & sw_lock_mask & pin_lock_mask;   // [RQ15]
        end
    end

    // Sequencer state and latched target
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state          <= FSP_IDLE;
            flash_op_addr  <= '0;
            flash_op_erase <= 1'b0;
            flash_op_start <= 1'b0;
            cpu_stall      <= 1'b0;
            denied         <= 1'b0;
            op_count       <= 16'h0000;
        end else begin
            flash_op_start <= 1'b0;
            case (state)
                FSP_IDLE: begin
                    if (start_ok) begin
                        state          <= FSP_RUN;
                        flash_op_addr  <= {addr_ptr[FSP_AW-1:FSP_PAGE_BITS],
                                           {FSP_PAGE_BITS{1'b0}}};   // [RQ16]
                        flash_op_erase <= w_data[FSP_CTRL_ERASE_BIT];
                        flash_op_start <= 1'b1;
                        cpu_stall      <= target_in_halt;            // [RQ8] [RQ17] [RQ14]
                        op_count       <= 16'h0000;
                        denied         <= 1'b0;
                    end else if (go_req) begin
                        // Nothing reaches the array; status shows the refusal
                        denied <= 1'b1;                              // Refused start
                    end
                end
                FSP_RUN: begin
                    // Counted so a silent array cannot hold the core forever
                    op_count <= op_count + 16'h0001;
                    if (done_q2 || timed_out) begin
                        state     <= FSP_DONE;
                        cpu_stall <= 1'b0;                           // [RQ17]
                    end
                end
                FSP_DONE: begin
                    // Wait for the array to drop done so one operation is not seen twice
                    if (!done_q2) begin
                        state <= FSP_IDLE;
                    end
                end
                default: begin
                    state     <= FSP_IDLE;
                    cpu_stall <= 1'b0;
                end
            endcase
        end
    end
    // Safety bound in case the array never answers
    assign timed_out = op_count >= 16'(PROG_CYCLES - 1);

    // Busy flag: set by a concurrent-read start, held until software clears it
    // A set beats a clear in one cycle; clears while running are ignored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_flag <= 1'b0;
        end else if (start_ok && !target_in_halt) begin
            busy_flag <= 1'b1;                                       // [RQ11] [RQ7]
        end else if (clr_req && state == FSP_IDLE) begin
            busy_flag <= 1'b0;                                       // [RQ12]
        end
    end

    // Block reads of the concurrent-read region while flag stands
    // Raised in the start cycle so no read slips in before the flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            concurrent_read_block <= 1'b0;
        end else begin
            concurrent_read_block <= busy_flag || (start_ok && !target_in_halt); // [RQ7] [RQ12]
        end
    end

    // Bit0 stays high until idle, so polling software never meets a refused start
    assign ctrl_read = {25'd0, busy_flag, 3'd0, 1'b0, flash_op_erase, 1'b0} | 32'(state != FSP_IDLE);

    // Read channel with one register stage
    // Unaligned offsets read zero with a slave error
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= FSP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= FSP_RESP_OKAY;
            case (s_axi_araddr)
                FSP_CTRL_OFS: s_axi_rdata <= ctrl_read;              // [RQ11]
                FSP_ADDR_OFS: s_axi_rdata <= 32'(addr_ptr);
                FSP_LOCK_OFS: s_axi_rdata <= {28'd0, lock_bits};
                FSP_STAT_OFS: s_axi_rdata <= {27'd0, denied, from_loader, fuse_q2, cpu_stall};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= FSP_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign next_rvalid   = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

    // Address is refused while read data still waits for the master
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !next_rvalid;
        end
    end

endmodule : fsp_sequencer

// ### tb/fsp_flash_model.sv
// Behavioural flash array answering page erase and write requests
`timescale 1ns/1ps
module fsp_flash_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       flash_op_start,
    input  wire logic [7:0] dly,
    output logic            flash_op_done
);
    int cnt;
    // Done rises dly cycles after start and holds 4 cycles so the synchroniser sees it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt           <= 0;
            flash_op_done <= 1'b0;
        end else if (flash_op_start) begin
            cnt <= 1;
        end else if (cnt != 0) begin
            cnt           <= (cnt == dly + 4) ? 0 : cnt + 1;
            flash_op_done <= cnt >= dly && cnt < dly + 4;
        end
    end
endmodule : fsp_flash_model

// ### tb/fsp_sequencer_assertions.sv
// Port-level assertions for the flash self-programming sequencer
`timescale 1ns/1ps
module fsp_sequencer_assertions
    import fsp_pkg::*;
#(
    parameter int PROG_CYCLES = FSP_PROG_CYCLES
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [3:0]        s_axi_awaddr,
    input wire logic              s_axi_wvalid,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic [FSP_AW-1:0] cpu_fetch_addr,
    input wire logic [1:0]        loader_size_fuses,
    input wire logic              cpu_stall,
    input wire logic              concurrent_read_block,
    input wire logic              flash_op_start,
    input wire logic [FSP_AW-1:0] flash_op_addr
);
    logic [11:0] ldr_base;
    logic [3:0]  ldr_hist;
    logic [2:0]  clr_hist;
    int          stall_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Loader start for the present fuse code
    assign ldr_base = loader_size_fuses[1] ? (loader_size_fuses[0] ? FSP_LDR_BASE_3 : FSP_LDR_BASE_2)
                                           : (loader_size_fuses[0] ? FSP_LDR_BASE_1 : FSP_LDR_BASE_0);
    // Short histories, since fuses and writes reach the core a few cycles late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ldr_hist  <= 4'h0;
            clr_hist  <= 3'h0;
            stall_cnt <= 0;
        end else begin
            ldr_hist  <= {ldr_hist[2:0], cpu_fetch_addr >= ldr_base};
            clr_hist  <= {clr_hist[1:0], s_axi_wvalid && s_axi_awaddr == FSP_CTRL_OFS && s_axi_wdata[FSP_CTRL_CLR_BIT]};
            stall_cnt <= cpu_stall ? stall_cnt + 1 : 0;
        end
    end
    a_halt_stall: assert property (flash_op_start && flash_op_addr >= FSP_HALT_BASE |-> ##[0:1] cpu_stall)
        else $error("halting page op without stall");
    a_conc_run: assert property (flash_op_start && flash_op_addr < FSP_HALT_BASE |-> !cpu_stall [*2])
        else $error("concurrent page op stalled the core");
    a_conc_block: assert property (flash_op_start && flash_op_addr < FSP_HALT_BASE |-> ##[0:1] concurrent_read_block)
        else $error("busy flag missing during concurrent op");
    a_busy_sticky: assert property ($fell(concurrent_read_block) |-> clr_hist != 3'h0)
        else $error("busy flag dropped without a clear");
    a_addr_held: assert property (cpu_stall |=> $stable(flash_op_addr))
        else $error("target address moved during op");
    a_loader_only: assert property (flash_op_start |-> ldr_hist != 4'h0)
        else $error("op started from outside the loader");
    a_page_start: assert property (flash_op_start |-> flash_op_addr[FSP_PAGE_BITS-1:0] == '0)
        else $error("target address not page aligned");
    a_start_pulse: assert property (flash_op_start |=> !flash_op_start)
        else $error("start held longer than one cycle");
    a_stall_bound: assert property (cpu_stall |-> stall_cnt <= PROG_CYCLES + 4)
        else $error("stall outlived the operation");
    c_conc_op: cover property (flash_op_start && flash_op_addr < FSP_HALT_BASE);
    c_halt_op: cover property (flash_op_start && flash_op_addr >= FSP_HALT_BASE);
    c_busy_clr: cover property ($fell(concurrent_read_block));
endmodule : fsp_sequencer_assertions
bind fsp_sequencer fsp_sequencer_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clk, .rst, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wdata, .cpu_fetch_addr, .loader_size_fuses,
    .cpu_stall, .concurrent_read_block, .flash_op_start, .flash_op_addr
);

// ### tb/fsp_sequencer_test.sv
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module fsp_sequencer_test;
    import fsp_pkg::*;
    localparam int PROG = 20;  // Short limit keeps the slow case brief
    logic        clk, rst, chip_erase, prog_lock_we, cpu_stall, concurrent_read_block;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, prog_lock_data;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, loader_size_fuses, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] cpu_fetch_addr, flash_op_addr;
    logic        flash_op_start, flash_op_erase, flash_op_done;
    logic [7:0]  dly;
    int          err_total = 0, compares = 0, starts = 0;
    fsp_sequencer #(.PROG_CYCLES(PROG)) uut (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .cpu_fetch_addr, .loader_size_fuses, .chip_erase, .prog_lock_we, .prog_lock_data, .cpu_stall,
        .concurrent_read_block, .flash_op_start, .flash_op_erase, .flash_op_addr, .flash_op_done
    );
    fsp_flash_model u_flash (.clk, .rst, .flash_op_start, .dly, .flash_op_done);
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Count start pulses seen by the array
    always @(posedge clk) if (flash_op_start === 1'b1) starts <= starts + 1;
    task automatic test_done;
        if (err_total == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic stuck;
        err_total++;
        $display("unexpected at %0t: no answer", $time);
        test_done();
    endtask : stuck
    // Write: offer address and data together, release each once taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
        int n;
        logic aw_go, w_go, b_go;
        n = 0;
        b_go = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        while (!b_go) begin
            @(negedge clk);
            aw_go = s_axi_awvalid && s_axi_awready;
            w_go  = s_axi_wvalid && s_axi_wready;
            b_go  = s_axi_bvalid;
            resp  = s_axi_bresp;
            @(posedge clk);
            if (aw_go) s_axi_awvalid <= 1'b0;
            if (w_go) s_axi_wvalid <= 1'b0;
            if (++n > 50) stuck();
        end
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n;
        logic ar_go, r_go;
        n = 0;
        r_go = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        while (!r_go) begin
            @(negedge clk);
            ar_go = s_axi_arvalid && s_axi_arready;
            r_go  = s_axi_rvalid;
            v     = s_axi_rdata;
            resp  = s_axi_rresp;
            @(posedge clk);
            if (ar_go) s_axi_arvalid <= 1'b0;
            if (++n > 50) stuck();
        end
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask : axi_rd
    // One store instruction: set pointer, fire, move pointer mid-op, wait idle
    task automatic op(input logic [11:0] a, input logic er, input logic ok);
        int n0, n;
        logic conc;
        n0 = starts;
        n = 0;
        conc = ok && a < FSP_HALT_BASE;
        axi_wr(FSP_ADDR_OFS, {20'h0_0000, a}, r);
        axi_wr(FSP_CTRL_OFS, {30'h0000_0000, er, 1'b1}, r);
        chk(cpu_stall, ok && !conc);
        chk(concurrent_read_block, conc);
        if (!ok) begin
            axi_rd(FSP_STAT_OFS, d, r);
            chk({d[4], r}, {1'b1, FSP_RESP_OKAY});
        end
        axi_wr(FSP_ADDR_OFS, 32'h0000_0000, r);
        if (ok) chk({flash_op_erase, flash_op_addr}, {er, a[11:5], 5'h00});
        do begin
            axi_rd(FSP_CTRL_OFS, d, r);
            if (++n > 40) stuck();
        end while (d[0] !== 1'b0);
        chk(starts - n0, ok);
        if (conc) begin
            chk(d[FSP_CTRL_BUSY_BIT], 1'b1);
            axi_wr(FSP_CTRL_OFS, 32'h0000_0008, r);
            axi_rd(FSP_CTRL_OFS, d, r);
            chk(d[FSP_CTRL_BUSY_BIT], 1'b0);
        end
    endtask : op
    initial begin
        {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h00_0000_0000;
        {chip_erase, prog_lock_we, prog_lock_data, loader_size_fuses} = 8'h00;
        cpu_fetch_addr = 12'h100;  // Application code, which software keeps out of during concurrent ops
        dly = 8'h0C;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        axi_rd(FSP_LOCK_OFS, d, r);
        chk(d[3:0], FSP_LOCK_RESET);
        axi_wr(4'h2, 32'h0000_0001, r);
        chk(r, FSP_RESP_SLVERR);
        axi_rd(4'h2, d, r);
        chk(r, FSP_RESP_SLVERR);
        op(12'h200, 1'b1, 1'b0);
        cpu_fetch_addr <= 12'hC10;  // Loader code stays in the halting region
        op(12'h200, 1'b1, 1'b1);
        op(12'hE47, 1'b0, 1'b1);
        dly <= 8'h28;
        op(12'hD00, 1'b0, 1'b1);
        dly <= 8'h0C;
        loader_size_fuses <= 2'h3;
        repeat (3) @(posedge clk);
        op(12'h300, 1'b1, 1'b0);
        cpu_fetch_addr <= 12'hF90;
        op(12'h300, 1'b1, 1'b1);
        axi_wr(FSP_LOCK_OFS, 32'h0000_000C, r);
        op(12'h300, 1'b1, 1'b0);
        op(12'hFA0, 1'b1, 1'b1);
        prog_lock_data <= 4'h3;
        prog_lock_we <= 1'b1;
        @(posedge clk);
        prog_lock_we <= 1'b0;
        op(12'hFA0, 1'b1, 1'b0);
        chip_erase <= 1'b1;
        repeat (4) @(posedge clk);
        chip_erase <= 1'b0;
        repeat (3) @(posedge clk);
        axi_rd(FSP_LOCK_OFS, d, r);
        chk(d[3:0], 4'hF);
        op(12'h300, 1'b1, 1'b1);
        test_done();
    end
endmodule : fsp_sequencer_test
